// ==== hw/zco_zone_call_top.sv ====
`timescale 1ns/100ps
`include "zco_consts.svh"
module zco_zone_call_top #(
  parameter int unsigned TICK_CYCLES = `ZCO_TICK_MS * `ZCO_CLK_KHZ
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [9:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic [23:0] zoneOccupied,
  input  wire logic        scanHit,
  input  wire logic        scanSweep,
  output logic      [23:0] zoneCall,
  output logic      [15:0] chanCall,
  output logic             failSafe,
  output logic             irq
);
  import zco_pkg::*;
  localparam int NZ = `ZCO_ZONES;

  logic [23:0] occS1;
  logic [23:0] occS2;
  logic [1:0]  scanS;
  logic [2:0]  sweepS;
  logic [31:0] tickCnt;
  logic        tick;
  zco_mode_t   zMode [NZ];
  logic [3:0]  zChan [NZ];
  logic [7:0]  zTime [NZ];
  logic [2:0]  zLane [NZ];
  logic [8:0]  zTop  [NZ];
  logic [8:0]  zHgt  [NZ];
  logic [8:0]  zWid  [NZ];
  logic [15:0] liveCnt [NZ];
  logic [15:0] binCnt  [NZ];
  logic [15:0] binPeriod;
  logic [15:0] binTimer;
  logic        binRoll;
  logic [2:0]  status;
  logic [2:0]  enable;
  logic [2:0]  events;
  logic [2:0]  laneSel;
  logic        goodSeen;
  logic        anyCref;
  logic        sweepEnd;
  logic        wrZone;
  logic        wrGeo;
  logic [4:0]  zIdx;
  logic        cfgOk;
  logic        geoOk;
  logic        rejectEv;
  logic [23:0] unitCall;
  logic [23:0] unitPassed;
  logic [23:0] next_zoneCall;
  logic [15:0] next_chanCall;
  logic [31:0] next_rdata;

  function automatic logic geomOk(input logic [8:0] top,
                                  input logic [8:0] h,
                                  input logic [8:0] w);
    geomOk = ({1'b0, top} + {1'b0, h} <= {1'b0, `ZCO_LC_ROWS}) &&
             (h < `ZCO_LC_MAX_PIX) && (w < `ZCO_LC_MAX_PIX);
  endfunction : geomOk

  function automatic logic [4:0] tallyCount();
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < NZ; i++) begin
      if (zMode[i] == TALLY) n = n + 5'h01;
    end
    tallyCount = n;
  endfunction : tallyCount

  function automatic logic [23:0] laneMask(input logic [2:0] ln);
    logic [23:0] m;
    logic [4:0]  n;
    m = 24'h00_0000;
    n = 5'h00;
    for (int i = 0; i < NZ; i++) begin
      if (zLane[i] == ln && zChan[i] != 4'h0) begin
        m[i] = 1'b1;
        n = n + 5'h01;
      end
    end
    laneMask = (n >= 5'h02) ? m : 24'h00_0000;
  endfunction : laneMask

  function automatic logic [17:0] laneExtent(input logic [23:0] m);
    logic [8:0] lo;
    logic [9:0] hi;
    logic [9:0] bot;
    logic [8:0] front;
    logic [9:0] back;
    lo = 9'h1ff;
    hi = 10'h000;
    for (int i = 0; i < NZ; i++) begin
      bot = {1'b0, zTop[i]} + {1'b0, zHgt[i]};
      if (m[i] && zTop[i] < lo) lo = zTop[i];
      if (m[i] && bot > hi) hi = bot;
    end
    front = (lo > `ZCO_LANE_MARGIN) ? lo - `ZCO_LANE_MARGIN : 9'h000;
    back = hi + {1'b0, `ZCO_LANE_MARGIN};
    if (back >= {1'b0, `ZCO_IMG_ROWS}) back = {1'b0, `ZCO_IMG_ROWS - 9'h001};
    laneExtent = (m == 24'h00_0000) ? 18'h0_0000 : {back[8:0], front};
  endfunction : laneExtent

  // Pin synchronisers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      occS1  <= 24'h00_0000;
      occS2  <= 24'h00_0000;
      scanS  <= 2'h0;
      sweepS <= 3'h0;
    end else begin
      occS1  <= zoneOccupied;
      occS2  <= occS1;
      scanS  <= {scanS[0], scanHit};
      sweepS <= {sweepS[1:0], scanSweep};
    end
  end

  // Time base
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (tickCnt >= TICK_CYCLES - 32'h0000_0001) begin
      tickCnt <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      tickCnt <= tickCnt + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

  // Write decode and configuration checks
  always_comb begin
    zIdx   = regAddr[6:2];
    wrZone = regWr && regAddr[9:8] == `ZCO_R_ZCFG && regAddr[7:2] < 6'h18;
    wrGeo  = regWr && regAddr[9:8] == `ZCO_R_ZGEO && regAddr[7:2] < 6'h18;
    cfgOk  = 1'b0;
    geoOk  = 1'b0;
    if (wrZone) begin
      cfgOk = regWdata[`ZCO_F_MODE] != 3'h7 &&
              regWdata[`ZCO_F_TIME] >= `ZCO_TIME_MIN &&
              regWdata[`ZCO_F_TIME] <= `ZCO_TIME_MAX;
      if (regWdata[`ZCO_F_MODE] == TALLY && zMode[zIdx] != TALLY &&
          tallyCount() >= `ZCO_MAX_TALLY) begin
        cfgOk = 1'b0;
      end
      if (regWdata[`ZCO_F_MODE] == CONTRAST_REF &&
          !geomOk(zTop[zIdx], zHgt[zIdx], zWid[zIdx])) begin
        cfgOk = 1'b0;
      end
    end
    if (wrGeo) begin
      geoOk = zMode[zIdx] != CONTRAST_REF ||
              geomOk(regWdata[`ZCO_F_TOP], regWdata[`ZCO_F_HGT],
                     regWdata[`ZCO_F_WID]);
    end
    rejectEv = (wrZone && !cfgOk) || (wrGeo && !geoOk);
  end

  // Zone configuration store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NZ; i++) begin
        zMode[i] <= OCCUPANCY_CALL;
        zChan[i] <= 4'h0;
        zTime[i] <= `ZCO_RST_TIME;
        zLane[i] <= 3'h0;
        zTop[i]  <= 9'h000;
        zHgt[i]  <= 9'h000;
        zWid[i]  <= 9'h000;
      end
    end else if (wrZone && cfgOk) begin
      zMode[zIdx] <= zco_mode_t'(regWdata[`ZCO_F_MODE]);
      zChan[zIdx] <= regWdata[`ZCO_F_CHAN];
      zTime[zIdx] <= regWdata[`ZCO_F_TIME];
      zLane[zIdx] <= regWdata[`ZCO_F_LANE];
    end else if (wrGeo && geoOk) begin
      zTop[zIdx] <= regWdata[`ZCO_F_TOP];
      zHgt[zIdx] <= regWdata[`ZCO_F_HGT];
      zWid[zIdx] <= regWdata[`ZCO_F_WID];
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      binPeriod <= `ZCO_RST_BINPER;
      enable    <= 3'h0;
      laneSel   <= 3'h0;
    end else if (regWr) begin
      if (regAddr == `ZCO_A_BINPER) binPeriod <= regWdata[15:0];
      if (regAddr == `ZCO_A_ENABLE) enable <= regWdata[2:0];
      if (regAddr == `ZCO_A_LANESEL) laneSel <= regWdata[2:0];
    end
  end

  // Per-zone call units
  zco_zone_if zi [NZ] ();
  for (genvar g = 0; g < NZ; g++) begin : gZone
    assign zi[g].tick     = tick;
    assign zi[g].mode     = zMode[g];
    assign zi[g].timeVal  = zTime[g];
    assign zi[g].occupied = occS2[g];
    assign unitCall[g]    = zi[g].call;
    assign unitPassed[g]  = zi[g].passed;
    zco_zone_unit uUnit (
      .clk    (clk),
      .arst_n (arst_n),
      .zb     (zi[g].unit)
    );
  end

  // Call outputs with fail-safe override
  always_comb begin
    next_chanCall = 16'h0000;
    for (int i = 0; i < NZ; i++) begin
      next_zoneCall[i] = unitCall[i];
      if (failSafe && (zMode[i] == OCCUPANCY_CALL || zMode[i] == STRETCHED_CALL ||
          zMode[i] == DEFERRED_CALL || zMode[i] == ONE_SHOT_CALL)) begin
        next_zoneCall[i] = 1'b1;
      end
      if (zMode[i] == NO_CALL) next_zoneCall[i] = 1'b0;
      if (next_zoneCall[i] && zChan[i] != 4'h0) next_chanCall[zChan[i]] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zoneCall <= 24'h00_0000;
      chanCall <= 16'h0000;
    end else begin
      zoneCall <= next_zoneCall;
      chanCall <= next_chanCall;
    end
  end

  // Contrast status per scan sweep
  always_comb begin
    anyCref = 1'b0;
    for (int i = 0; i < NZ; i++) begin
      if (zMode[i] == CONTRAST_REF) anyCref = 1'b1;
    end
    sweepEnd = sweepS[1] && !sweepS[2];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      goodSeen <= 1'b0;
      failSafe <= 1'b0;
    end else if (sweepEnd) begin
      goodSeen <= 1'b0;
      failSafe <= anyCref && !(goodSeen || scanS[1]);
    end else begin
      goodSeen <= goodSeen || scanS[1];
      if (!anyCref) failSafe <= 1'b0;
    end
  end

  // Count bins
  assign binRoll = tick && binPeriod != 16'h0000 &&
                   binTimer >= binPeriod - 16'h0001;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      binTimer <= 16'h0000;
    end else if (binRoll) begin
      binTimer <= 16'h0000;
    end else if (tick) begin
      binTimer <= binTimer + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NZ; i++) begin
        liveCnt[i] <= 16'h0000;
        binCnt[i]  <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NZ; i++) begin
        if (binRoll) begin
          binCnt[i]  <= liveCnt[i];
          liveCnt[i] <= {15'h0000, unitPassed[i]};
        end else if (zMode[i] != TALLY) begin
          liveCnt[i] <= 16'h0000;
        end else if (unitPassed[i] && liveCnt[i] != 16'hffff) begin
          liveCnt[i] <= liveCnt[i] + 16'h0001;
        end
      end
    end
  end

  // Interrupt status, set wins over clear
  always_comb begin
    events = 3'h0;
    events[`ZCO_EV_BIN] = binRoll;
    events[`ZCO_EV_LC]  = sweepEnd && anyCref && !(goodSeen || scanS[1]) && !failSafe;
    events[`ZCO_EV_REJ] = rejectEv;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= 3'h0;
      irq    <= 1'b0;
    end else begin
      if (regWr && regAddr == `ZCO_A_CLEAR) begin
        status <= (status & ~regWdata[2:0]) | events;
      end else begin
        status <= status | events;
      end
      irq <= |(status & enable);
    end
  end

  // Register read port
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (regAddr[9:8])
      `ZCO_R_ZCFG: begin
        if (regAddr[7:2] < 6'h18) begin
          next_rdata[`ZCO_F_MODE] = zMode[zIdx];
          next_rdata[`ZCO_F_CHAN] = zChan[zIdx];
          next_rdata[`ZCO_F_TIME] = zTime[zIdx];
          next_rdata[`ZCO_F_LANE] = zLane[zIdx];
        end
      end
      `ZCO_R_ZGEO: begin
        if (regAddr[7:2] < 6'h18) begin
          next_rdata[`ZCO_F_TOP] = zTop[zIdx];
          next_rdata[`ZCO_F_HGT] = zHgt[zIdx];
          next_rdata[`ZCO_F_WID] = zWid[zIdx];
        end
      end
      `ZCO_R_ZBIN: begin
        if (regAddr[7:2] < 6'h18) next_rdata[15:0] = binCnt[zIdx];
      end
      default: begin
        unique case (regAddr)
          `ZCO_A_BINPER:   next_rdata[15:0] = binPeriod;
          `ZCO_A_STATUS:   next_rdata[2:0]  = status;
          `ZCO_A_ENABLE:   next_rdata[2:0]  = enable;
          `ZCO_A_LCSTAT:   next_rdata[1:0]  = {anyCref, failSafe};
          `ZCO_A_LANESEL:  next_rdata[2:0]  = laneSel;
          `ZCO_A_LANEMEM:  next_rdata[23:0] = laneMask(laneSel);
          `ZCO_A_LANEEXT:  next_rdata[17:0] = laneExtent(laneMask(laneSel));
          `ZCO_A_CALLS:    next_rdata[23:0] = zoneCall;
          `ZCO_A_TALLYCNT: next_rdata[4:0]  = tallyCount();
          default:         next_rdata = 32'h0000_0000;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRd ? next_rdata : 32'h0000_0000;
    end
  end
endmodule : zco_zone_call_top

// ==== hw/zco_consts.svh ====
`ifndef ZCO_CONSTS_SVH
`define ZCO_CONSTS_SVH
`define ZCO_ZONES       24
`define ZCO_MAX_TALLY   5'h06
`define ZCO_TIME_MIN    8'h01
`define ZCO_TIME_MAX    8'hfa
`define ZCO_TICK_MS     100
`define ZCO_CLK_KHZ     50000
`define ZCO_IMG_ROWS    9'h1e0
`define ZCO_LC_ROWS     (`ZCO_IMG_ROWS / 9'h003)
`define ZCO_LC_MAX_PIX  9'h008
`define ZCO_LANE_MARGIN 9'h010
`define ZCO_A_BINPER    10'h000
`define ZCO_A_STATUS    10'h004
`define ZCO_A_CLEAR     10'h008
`define ZCO_A_ENABLE    10'h00c
`define ZCO_A_LCSTAT    10'h010
`define ZCO_A_LANESEL   10'h014
`define ZCO_A_LANEMEM   10'h018
`define ZCO_A_LANEEXT   10'h01c
`define ZCO_A_CALLS     10'h020
`define ZCO_A_TALLYCNT  10'h024
`define ZCO_R_ZCFG      2'h1
`define ZCO_R_ZGEO      2'h2
`define ZCO_R_ZBIN      2'h3
`define ZCO_F_MODE      2:0
`define ZCO_F_CHAN      6:3
`define ZCO_F_TIME      15:8
`define ZCO_F_LANE      18:16
`define ZCO_F_TOP       8:0
`define ZCO_F_HGT       17:9
`define ZCO_F_WID       26:18
`define ZCO_RST_TIME    8'h03
`define ZCO_RST_BINPER  16'h0258
`define ZCO_EV_BIN      0
`define ZCO_EV_LC       1
`define ZCO_EV_REJ      2
`endif

// ==== hw/zco_pkg.sv ====
package zco_pkg;
  typedef enum logic [2:0] {
    OCCUPANCY_CALL, STRETCHED_CALL, DEFERRED_CALL, ONE_SHOT_CALL,
    TALLY, CONTRAST_REF, NO_CALL
  } zco_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OCC, ST_HOLD, ST_WAIT, ST_PULSE, ST_REARM
  } zco_ustate_t;
endpackage : zco_pkg

// ==== hw/zco_zone_if.sv ====
`timescale 1ns/100ps
interface zco_zone_if;
  import zco_pkg::*;
  logic       tick;
  zco_mode_t  mode;
  logic [7:0] timeVal;
  logic       occupied;
  logic       call;
  logic       passed;
  modport unit (input tick, input mode, input timeVal, input occupied,
                output call, output passed);
  modport ctrl (output tick, output mode, output timeVal, output occupied,
                input call, input passed);
endinterface : zco_zone_if

// ==== hw/zco_zone_unit.sv ====
`timescale 1ns/100ps
module zco_zone_unit (
  input wire logic clk,
  input wire logic arst_n,
  zco_zone_if.unit zb
);
  import zco_pkg::*;
  zco_ustate_t state;
  zco_ustate_t next_state;
  zco_mode_t   modeQ;
  logic [7:0]  timer;
  logic [7:0]  next_timer;
  logic        occPrev;
  logic        expire;

  assign expire = zb.tick && (timer <= 8'h01);

  always_comb begin
    next_state = state;
    next_timer = timer;
    if (zb.tick && timer != 8'h00) begin
      next_timer = timer - 8'h01;
    end
    if (zb.mode != modeQ) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (zb.occupied) begin
            unique case (zb.mode)
              OCCUPANCY_CALL, STRETCHED_CALL: next_state = ST_OCC;
              DEFERRED_CALL: begin
                next_state = ST_WAIT;
                next_timer = zb.timeVal;
              end
              ONE_SHOT_CALL: begin
                next_state = ST_PULSE;
                next_timer = zb.timeVal;
              end
              default: next_state = ST_IDLE;
            endcase
          end
        end
        ST_OCC: begin
          if (!zb.occupied && zb.mode == STRETCHED_CALL) begin
            next_state = ST_HOLD;
            next_timer = zb.timeVal;
          end else if (!zb.occupied) begin
            next_state = ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (zb.occupied) next_state = ST_OCC;
          else if (expire) next_state = ST_IDLE;
        end
        ST_WAIT: begin
          if (!zb.occupied) next_state = ST_IDLE;
          else if (expire) next_state = ST_OCC;
        end
        ST_PULSE: begin
          if (expire) next_state = zb.occupied ? ST_REARM : ST_IDLE;
        end
        ST_REARM: begin
          if (!zb.occupied) next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= ST_IDLE;
      timer   <= 8'h00;
      modeQ   <= OCCUPANCY_CALL;
      occPrev <= 1'b0;
      zb.call <= 1'b0;
      zb.passed <= 1'b0;
    end else begin
      state   <= next_state;
      timer   <= next_timer;
      modeQ   <= zb.mode;
      occPrev <= zb.occupied;
      zb.call <= (next_state == ST_OCC) || (next_state == ST_HOLD) ||
                 (next_state == ST_PULSE);
      zb.passed <= occPrev && !zb.occupied && zb.mode == TALLY;
    end
  end
endmodule : zco_zone_unit

// ==== verification/zco_ctrl_model.sv ====
`timescale 1ns/100ps
module zco_ctrl_model #(
  parameter int CH = 1
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [15:0] chanCall,
  output logic      [7:0]  onsets
);
  logic prev;
  // Counts call onsets seen on one detector input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev   <= 1'b0;
      onsets <= 8'h00;
    end else begin
      prev <= chanCall[CH];
      if (chanCall[CH] && !prev) begin
        onsets <= onsets + 8'h01;
      end
    end
  end
endmodule : zco_ctrl_model

// ==== verification/zco_call_properties.sv ====
`timescale 1ns/100ps
`include "zco_consts.svh"
module zco_call_props #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [9:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [23:0] zoneOccupied,
  input wire logic        scanHit,
  input wire logic        scanSweep,
  input wire logic [23:0] zoneCall,
  input wire logic [15:0] chanCall,
  input wire logic        failSafe,
  input wire logic        irq
);
  import zco_pkg::*;
  zco_mode_t   m0;
  logic [7:0]  t0;
  logic [3:0]  ch0;
  logic [3:0]  stab;
  logic [2:0]  fsq;
  logic [2:0]  fsOn;
  logic [15:0] pl;
  logic        cfgOk;
  logic        q;
  assign cfgOk = regWr && regAddr == 10'h100 && regWdata[2:0] != 3'h7
                 && regWdata[15:8] >= `ZCO_TIME_MIN && regWdata[15:8] <= `ZCO_TIME_MAX;
  assign q = stab >= 4'h8 && fsq >= 3'h6;
  // Zone 0 configuration as software wrote it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      m0  <= OCCUPANCY_CALL;
      t0  <= `ZCO_RST_TIME;
      ch0 <= 4'h0;
    end else if (cfgOk) begin
      m0  <= zco_mode_t'(regWdata[2:0]);
      t0  <= regWdata[15:8];
      ch0 <= regWdata[6:3];
    end
  end
  // Cycles since zone 0 setup changed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stab <= 4'h0;
    end else if (cfgOk) begin
      stab <= 4'h0;
    end else if (stab != 4'hf) begin
      stab <= stab + 4'h1;
    end
  end
  // Fail-safe age counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fsq  <= 3'h0;
      fsOn <= 3'h0;
    end else begin
      fsq  <= failSafe ? 3'h0 : (fsq == 3'h7 ? fsq : fsq + 3'h1);
      fsOn <= !failSafe ? 3'h0 : (fsOn == 3'h7 ? fsOn : fsOn + 3'h1);
    end
  end
  // Length of the current call on zone 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pl <= 16'h0000;
    end else begin
      pl <= zoneCall[0] ? pl + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_enter;
    $past(zoneOccupied[0], 4) && !$past(zoneOccupied[0], 5);
  endsequence
  a_presence_track: assert property (
    q && m0 == OCCUPANCY_CALL |-> zoneCall[0] == $past(zoneOccupied[0], 4))
    else $error("presence call not following occupancy");
  a_ext_covers_occ: assert property (
    q && m0 == STRETCHED_CALL && $past(zoneOccupied[0], 4) |-> zoneCall[0])
    else $error("extension call missing while occupied");
  a_delay_drops: assert property (
    q && m0 == DEFERRED_CALL && !$past(zoneOccupied[0], 4) |-> !zoneCall[0])
    else $error("delay call while unoccupied");
  a_delay_withheld: assert property (
    q && m0 == DEFERRED_CALL ##0 s_enter |-> !zoneCall[0])
    else $error("delay call at entry");
  a_pulse_on_entry: assert property (
    q && m0 == ONE_SHOT_CALL && $rose(zoneCall[0]) |-> s_enter)
    else $error("pulse without new entry");
  a_pulse_length: assert property (
    q && m0 == ONE_SHOT_CALL && $fell(zoneCall[0])
    |-> pl >= (t0 - 1) * TICK_CYCLES && pl <= t0 * TICK_CYCLES)
    else $error("pulse length wrong");
  a_nocall_silent: assert property (
    stab >= 4'h4 && m0 == NO_CALL |-> !zoneCall[0])
    else $error("none zone called");
  a_failsafe_calls: assert property (
    failSafe && fsOn >= 3'h3 && stab >= 4'h4 && m0 <= ONE_SHOT_CALL |-> zoneCall[0] [*2])
    else $error("no constant call in fail-safe");
  a_chan_or_zone: assert property (
    zoneCall[0] && ch0 != 4'h0 && stab >= 4'h4 |-> chanCall[ch0])
    else $error("channel call missing");
  a_read_idle_zero: assert property (
    !$past(regRd) |-> regRdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule : zco_call_props
bind zco_zone_call_top zco_call_props #(.TICK_CYCLES(TICK_CYCLES)) zco_call_props_inst (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .zoneOccupied(zoneOccupied), .scanHit(scanHit),
  .scanSweep(scanSweep), .zoneCall(zoneCall), .chanCall(chanCall), .failSafe(failSafe),
  .irq(irq));

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import zco_pkg::*;
  localparam int TK = 10;
  typedef struct {zco_mode_t mode; logic [7:0] tim; int occ; int lo; int hi;} zco_row_t;
  logic        clk;
  logic        arst_n;
  logic [9:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic [23:0] zoneOccupied;
  logic        scanHit;
  logic        scanSweep;
  logic [23:0] zoneCall;
  logic [15:0] chanCall;
  logic        failSafe;
  logic        irq;
  logic [7:0]  onsets;
  logic [7:0]  o0;
  logic [31:0] rv;
  int          fail_count;
  int          cmp_count;
  int          hiCnt;
  int          k;
  zco_row_t    rows[9];
  zco_zone_call_top #(.TICK_CYCLES(TK)) zco_zone_call_top_inst (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .zoneOccupied(zoneOccupied), .scanHit(scanHit),
    .scanSweep(scanSweep), .zoneCall(zoneCall), .chanCall(chanCall), .failSafe(failSafe),
    .irq(irq));
  zco_ctrl_model #(.CH(1)) zco_ctrl_model_inst (
    .clk(clk), .arst_n(arst_n), .chanCall(chanCall), .onsets(onsets));
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rv = regRdata;
  endtask : rd
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    rd(a);
    chk(rv === e, $sformatf("read %h got %h", a, rv));
  endtask : rdc
  task automatic occ(input int z, input int n);
    @(posedge clk);
    zoneOccupied[z] <= 1'b1;
    repeat (n) @(posedge clk);
    zoneOccupied[z] <= 1'b0;
  endtask : occ
  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #(20 * 100000);
    fail_count++;
    final_report();
  end
  initial begin
    {regAddr, regWdata, regWr, regRd, zoneOccupied, scanHit, scanSweep} = '0;
    arst_n = 1'b0;
    rows = '{'{OCCUPANCY_CALL, 8'h03, 40, 40, 40},
             '{STRETCHED_CALL, 8'h03, 40, 40 + 2 * TK, 40 + 3 * TK},
             '{STRETCHED_CALL, 8'hfa, 40, 40 + 249 * TK, 40 + 250 * TK},
             '{DEFERRED_CALL, 8'h03, 60, 60 - 3 * TK, 60 - 2 * TK},
             '{DEFERRED_CALL, 8'h05, 30, 0, 0},
             '{ONE_SHOT_CALL, 8'h03, 100, 2 * TK, 3 * TK},
             '{ONE_SHOT_CALL, 8'h01, 50, 1, TK},
             '{NO_CALL, 8'h03, 40, 0, 0},
             '{TALLY, 8'h03, 40, 0, 0}};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(10'h100, {16'h0000, rows[i].tim, 1'b0, 4'h1, rows[i].mode});
      repeat (8) @(posedge clk);
      hiCnt = 0;
      for (int n = 0; n < rows[i].occ + rows[i].tim * TK + 40; n++) begin
        @(posedge clk);
        zoneOccupied[0] <= (n < rows[i].occ);
        hiCnt += int'(zoneCall[0] === 1'b1);
        chk(chanCall[1] === zoneCall[0], "channel follows zone");
      end
      chk(hiCnt >= rows[i].lo && hiCnt <= rows[i].hi, "call length");
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk(zoneCall === 24'h00_0000 && irq === 1'b0 && failSafe === 1'b0, "reset outputs");
    rdc(10'h000, 32'h0000_0258);
    rdc(10'h100, 32'h0000_0300);
    rdc(10'h00c, 32'h0000_0000);
    rdc(10'h008, 32'h0000_0000);
    rdc(10'h3fc, 32'h0000_0000);
    wr(10'h00c, 32'h0000_0004);
    foreach (rows[i]) begin
      wr(10'h100, {16'h0000, (i < 3 ? 8'h00 : 8'hfb), 1'b0, 4'h1, (i < 6 ? 3'h1 : 3'h7)});
    end
    rdc(10'h100, 32'h0000_0300);
    rdc(10'h004, 32'h0000_0004);
    chk(irq === 1'b1, "irq raised");
    wr(10'h00c, 32'h0000_0000);
    rdc(10'h00c, 32'h0000_0000);
    chk(irq === 1'b0, "irq masked");
    wr(10'h008, 32'h0000_0004);
    wr(10'h00c, 32'h0000_0004);
    rdc(10'h004, 32'h0000_0000);
    chk(irq === 1'b0, "irq cleared");
    wr(10'h100, 32'h0000_020b);
    repeat (8) @(posedge clk);
    o0 = onsets;
    occ(0, 80);
    chk(onsets - o0 === 8'h01, "single pulse");
    repeat (10) @(posedge clk);
    occ(0, 40);
    repeat (10) @(posedge clk);
    chk(onsets - o0 === 8'h02, "re-armed pulse");
    for (k = 1; k < 8; k++) begin
      wr(10'h100 + 10'(4 * k), 32'h0000_0304);
    end
    rdc(10'h024, 32'h0000_0006);
    rdc(10'h11c, 32'h0000_0300);
    for (k = 0; k < 3; k++) begin
      occ(1, 10);
      repeat (10) @(posedge clk);
    end
    wr(10'h008, 32'h0000_0007);
    wr(10'h000, 32'h0000_0005);
    k = 0;
    rv = 32'h0000_0000;
    while (rv[0] !== 1'b1) begin
      k++;
      if (k > 40) begin
        fail_count++;
        final_report();
      end
      rd(10'h004);
    end
    chk(rv === 32'h0000_0001, "bin roll status");
    rdc(10'h304, 32'h0000_0003);
    wr(10'h000, 32'h0000_0000);
    wr(10'h220, {5'h00, 9'h014, 9'h028, 9'h064});
    wr(10'h224, {5'h00, 9'h014, 9'h028, 9'h096});
    wr(10'h22c, {5'h00, 9'h004, 9'h004, 9'h00a});
    wr(10'h120, 32'h0001_0316);
    wr(10'h124, 32'h0001_0316);
    wr(10'h128, 32'h0002_0316);
    wr(10'h12c, 32'h0001_0306);
    wr(10'h014, 32'h0000_0001);
    rdc(10'h018, 32'h0000_0300);
    rdc(10'h01c, {14'h0000, 9'h0ce, 9'h054});
    wr(10'h014, 32'h0000_0002);
    rdc(10'h018, 32'h0000_0000);
    wr(10'h008, 32'h0000_0007);
    wr(10'h234, {5'h00, 9'h004, 9'h004, 9'h0c8});
    wr(10'h134, 32'h0000_0305);
    rdc(10'h004, 32'h0000_0004);
    wr(10'h230, {5'h00, 9'h004, 9'h004, 9'h00a});
    wr(10'h130, 32'h0000_0305);
    wr(10'h100, 32'h0000_0308);
    rdc(10'h010, 32'h0000_0002);
    @(posedge clk);
    scanSweep <= 1'b1;
    repeat (4) @(posedge clk);
    scanSweep <= 1'b0;
    repeat (6) @(posedge clk);
    chk(failSafe === 1'b1 && zoneCall[0] === 1'b1 && chanCall[1] === 1'b1, "fail-safe on");
    rdc(10'h004, 32'h0000_0006);
    rdc(10'h010, 32'h0000_0003);
    @(posedge clk);
    scanHit <= 1'b1;
    repeat (4) @(posedge clk);
    scanSweep <= 1'b1;
    repeat (8) @(posedge clk);
    chk(failSafe === 1'b0 && zoneCall[0] === 1'b0, "fail-safe off");
    final_report();
  end
endmodule : testbench
